/* tdp_consts.vh */
`ifndef TDP_CONSTS_VH
`define TDP_CONSTS_VH

// Octet layout on the shared bus: line 0 is the LSB, line 7 the MSB
`define TDP_OCTET_W      8
`define TDP_OCTET_LSB    0
`define TDP_OCTET_MSB    7

// Up to four drives share one controller; two address bits
`define TDP_ADDR_W       2
`define TDP_HOME_ADDR    2'h0

// Positions of the host control lines in the synchroniser vector
`define TDP_CTL_W        4
`define TDP_CTL_LINK     0
`define TDP_CTL_CMD      1
`define TDP_CTL_RST      2
`define TDP_CTL_STRB     3

// Reset values of the line drivers and flags
`define TDP_CTL_RESET    4'h0
`define TDP_OCTET_RESET  8'h00
`define TDP_FLAG_RESET   1'b0

// Data buffer between the bus and the drive
`define TDP_BUF_DEPTH    2'h2
`define TDP_BUF_CNT_W    2

`endif

/* tdp_drive_port.v */
`timescale 1ns/10ps
`include "tdp_consts.vh"

module tdp_drive_port (
  input  wire                   clk,                // 40 MHz system clock
  input  wire                   reset,              // Async reset, active high
  // Bus pins, as seen inside the pad ring
  input  wire [7:0]             busIn,              // Data lines as received
  output reg  [7:0]             busOut,             // Data lines to drive
  output reg                    busOe,              // High while drive owns data lines
  input  wire                   busOddParityBitIn,  // Parity line as received
  output reg                    busOddParityBitOut, // Parity line to drive
  output reg                    busOddParityBitOe,  // High while parity is driven
  input  wire                   linkActiveFromHost, // Host link-active line
  input  wire                   cmdStrobe,          // Host command strobe line
  input  wire                   hostReset,          // Host reset line
  input  wire                   hostDataStrobe,     // Host data strobe line
  output wire                   ackOut,             // Acknowledge level
  output wire                   ackOe,              // Acknowledge driver enable
  output wire                   availOut,           // Available level
  output wire                   availOe,            // Available driver enable
  output wire                   driveAttention,     // Attention level
  output wire                   driveAttentionOe,   // Attention driver enable
  output wire                   turnOut,            // Turnaround level
  output wire                   turnOe,             // Turnaround driver enable
  // Drive side
  input  wire [`TDP_ADDR_W-1:0] devAddr,            // This drive's address
  input  wire                   parityEnable,       // Parity line in use
  input  wire                   selectHit,          // Pulse: select names this drive
  input  wire                   selectMiss,         // Pulse: select names another drive
  input  wire                   mechReady,          // Drive can take a new command
  input  wire                   readMode,           // Transfers flow toward the host
  input  wire                   searchActive,       // Repositioning, no octets out
  input  wire                   streamActive,       // Tape is streaming
  input  wire                   exceptionIn,        // Pulse: operation cannot go on
  input  wire                   attnClear,          // Pulse: exception reported
  output reg                    cmdValid,           // Command octet waiting
  input  wire                   cmdReady,           // Firmware takes command
  output reg  [7:0]             cmdData,            // Command octet
  output wire                   wrValid,            // Host octet available
  input  wire                   wrReady,            // Tape side takes host octet
  output wire [7:0]             wrData,             // Host octet
  input  wire                   rdValid,            // Tape side offers octet
  output wire                   rdReady,            // Octet accepted
  input  wire [7:0]             rdData,             // Octet for the host
  output reg                    parityErr,          // Pulse: bad parity on take
  output reg                    underrun,           // High while host too slow
  output wire                   linkActive,         // Synchronised link-active
  output wire                   selected            // Drive owns the bus
);

  localparam ST_IDLE = 1'b0;
  localparam ST_ACK  = 1'b1;

  reg [`TDP_CTL_W-1:0] meta_ff;
  reg [`TDP_CTL_W-1:0] sync_ff;
  reg                  hrstPrev_ff;
  reg                  state_ff;
  reg                  nxt_state;
  reg                  ack_ff;
  reg                  turn_ff;
  reg                  selected_ff;
  reg                  attn_ff;
  reg                  pushBus;
  reg                  popBus;
  reg                  takeCmd;

  wire       cmdS;
  wire       hrstS;
  wire       strbS;
  wire       bufInValid;
  wire       bufInReady;
  wire [7:0] bufInData;
  wire       bufOutValid;
  wire       bufOutReady;
  wire [7:0] bufOutData;
  wire       parityBad;
  wire       hrstFall;
  wire       busyIdle;

  // Two-stage synchroniser on every host control line; first stage read by second only
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_ff <= `TDP_CTL_RESET;
      sync_ff <= `TDP_CTL_RESET;
    end else begin
      meta_ff <= {hostDataStrobe, hostReset, cmdStrobe, linkActiveFromHost};
      sync_ff <= meta_ff;
    end
  end

  assign linkActive = sync_ff[`TDP_CTL_LINK];
  assign cmdS       = sync_ff[`TDP_CTL_CMD];
  assign hrstS      = sync_ff[`TDP_CTL_RST];
  assign strbS      = sync_ff[`TDP_CTL_STRB];
  assign hrstFall   = hrstPrev_ff & ~hrstS;
  assign selected   = selected_ff;

  // Odd parity over the nine lines; ignored when the line is unused
  assign parityBad = parityEnable & ~(^{busOddParityBitIn, busIn});

  // Buffer feeds from the bus when writing, from the tape side when reading
  assign bufInValid  = turn_ff ? (rdValid & ~searchActive) : pushBus;
  assign bufInData   = turn_ff ? rdData : busIn;
  assign bufOutReady = turn_ff ? popBus : wrReady;
  assign wrValid     = ~turn_ff & bufOutValid;
  assign wrData      = bufOutData;
  // Search drains octets from the tape side so none reach the host
  assign rdReady     = searchActive | (turn_ff & bufInReady);

  tdp_pair_buf #(
    .WIDTH (`TDP_OCTET_W)
  ) u_buf (
    .clk      (clk),
    .reset    (reset),
    .flush    (hrstS),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .inData   (bufInData),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOutData)
  );

  // Handshake decisions: one octet per strobe, acknowledged until strobes drop
  always @* begin
    nxt_state = state_ff;
    pushBus   = 1'b0;
    popBus    = 1'b0;
    takeCmd   = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (selected_ff & ~hrstS) begin
          // Command strobe honoured only while attention or available shows
          if (cmdS & (attn_ff | availOut) & ~cmdValid) begin
            takeCmd   = 1'b1;
            nxt_state = ST_ACK;
          end else if (strbS & ~turn_ff & bufInReady) begin
            pushBus   = 1'b1;
            nxt_state = ST_ACK;
          end else if (strbS & turn_ff & bufOutValid) begin
            popBus    = 1'b1;
            nxt_state = ST_ACK;
          end
        end
      end
      ST_ACK: begin
        if (~cmdS & ~strbS) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // State, acknowledge and data drivers
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_ff           <= ST_IDLE;
      ack_ff             <= `TDP_FLAG_RESET;
      busOut             <= `TDP_OCTET_RESET;
      busOe              <= `TDP_FLAG_RESET;
      busOddParityBitOut <= `TDP_FLAG_RESET;
      busOddParityBitOe  <= `TDP_FLAG_RESET;
    end else if (hrstS) begin
      state_ff          <= ST_IDLE;
      ack_ff            <= 1'b0;
      busOe             <= 1'b0;
      busOddParityBitOe <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ack_ff   <= (nxt_state == ST_ACK);
      if (popBus) begin
        busOut             <= bufOutData;
        busOddParityBitOut <= ~(^bufOutData);
        busOe              <= 1'b1;
        busOddParityBitOe  <= parityEnable;
      end else if (nxt_state == ST_IDLE) begin
        // Release the data lines once the host has let go of its strobe
        busOe             <= 1'b0;
        busOddParityBitOe <= 1'b0;
      end
    end
  end

  // Command octet held for firmware; a new one waits until this is taken
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cmdValid <= `TDP_FLAG_RESET;
      cmdData  <= `TDP_OCTET_RESET;
    end else if (hrstS) begin
      cmdValid <= 1'b0;
    end else if (takeCmd) begin
      cmdValid <= 1'b1;
      cmdData  <= busIn;
    end else if (cmdReady) begin
      cmdValid <= 1'b0;
    end
  end

  // Parity error is a one-cycle pulse; underrun stays high while its condition holds
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      parityErr <= `TDP_FLAG_RESET;
      underrun  <= `TDP_FLAG_RESET;
    end else begin
      parityErr <= (takeCmd | pushBus) & parityBad;
      // Tape wants an octet with none buffered, or offers one with no room
      underrun <= streamActive & ~searchActive &
                  ((~turn_ff & wrReady & ~bufOutValid) |
                   (turn_ff & rdValid & ~bufInReady));
    end
  end

  // Direction may only turn while idle and drained, so no octet changes sides
  assign busyIdle = (state_ff == ST_IDLE) & ~bufOutValid;

  // Selection, direction and attention; host reset rehomes the bus to address zero
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      hrstPrev_ff <= `TDP_FLAG_RESET;
      selected_ff <= `TDP_FLAG_RESET;
      turn_ff     <= `TDP_FLAG_RESET;
      attn_ff     <= `TDP_FLAG_RESET;
    end else begin
      hrstPrev_ff <= hrstS;
      if (hrstS) begin
        selected_ff <= 1'b0;
        turn_ff     <= 1'b0;
        attn_ff     <= 1'b0;
      end else begin
        if (hrstFall) begin
          selected_ff <= (devAddr == `TDP_HOME_ADDR);
        end else if (selectHit) begin
          selected_ff <= 1'b1;
        end else if (selectMiss) begin
          selected_ff <= 1'b0;
        end
        if (busyIdle) begin
          turn_ff <= readMode;
        end
        // A new exception in the clearing cycle keeps attention up
        if ((hrstFall & (devAddr == `TDP_HOME_ADDR)) | exceptionIn) begin
          attn_ff <= 1'b1;
        end else if (attnClear) begin
          attn_ff <= 1'b0;
        end
      end
    end
  end

  // Drive-owned controls: asserted level, driver enabled only when selected
  assign ackOut           = ack_ff;
  assign availOut         = mechReady & ~attn_ff;
  assign driveAttention   = attn_ff;
  assign turnOut          = turn_ff;
  assign ackOe            = selected_ff;
  assign availOe          = selected_ff;
  assign driveAttentionOe = selected_ff;
  assign turnOe           = selected_ff;

endmodule // tdp_drive_port

/* tdp_drive_port_sva.sv */
`timescale 1ns/10ps

// Port checks on the drive side of the shared tape bus
module tdp_drive_port_sva (
  input wire       clk,                // Clock
  input wire       reset,              // Async reset
  input wire [7:0] busOut,             // Data out
  input wire       busOe,              // Data enable
  input wire       busOddParityBitOut, // Parity out
  input wire       busOddParityBitOe,  // Parity enable
  input wire       cmdStrobe,          // Host strobe
  input wire       hostReset,          // Host reset
  input wire       hostDataStrobe,     // Host data strobe
  input wire       ackOut,             // Acknowledge
  input wire       ackOe,              // Ack enable
  input wire       availOut,           // Available
  input wire       driveAttention,     // Attention
  input wire       turnOut,            // Turnaround
  input wire       turnOe,             // Turn enable
  input wire [1:0] devAddr,            // Address
  input wire       selected,           // Bus owner
  input wire       searchActive,       // Searching
  input wire       rdValid,            // Tape offers
  input wire       rdReady,            // Octet taken
  input wire       cmdValid            // Command out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Ack only follows a strobe that crossed both synchroniser stages
  a_ack_after_sync: assert property (
    $rose(ackOut) |-> $past(cmdStrobe, 3) || $past(hostDataStrobe, 3))
    else $error("ack rose without strobe three edges earlier");
  a_ack_release: assert property (
    (!cmdStrobe && !hostDataStrobe) [*4] |-> !ackOut)
    else $error("ack held after strobes dropped");
  a_par_odd: assert property (
    busOddParityBitOe |-> ^{busOddParityBitOut, busOut})
    else $error("driven parity not odd");
  a_turn_read: assert property (
    busOe |-> turnOut && turnOe)
    else $error("data driven without turnaround");
  a_release_unsel: assert property (
    !selected |-> !ackOe && !busOe)
    else $error("unselected drive drives lines");
  a_cmd_gate: assert property (
    $rose(cmdValid) |-> $past(driveAttention || availOut))
    else $error("command taken outside attention or available");
  a_search_sink: assert property (
    searchActive && rdValid |-> rdReady)
    else $error("search octet not swallowed");
  a_home_attn: assert property (
    $fell(hostReset) && devAddr == 2'h0 |-> ##3 selected && driveAttention)
    else $error("home drive did not take bus");
endmodule // tdp_drive_port_sva

bind tdp_drive_port tdp_drive_port_sva tdp_drive_port_sva_i (.*);

/* tdp_drive_port_tb.sv */
`timescale 1ns/10ps

module tdp_drive_port_tb;
  logic       clk = 1'h0, reset = 1'h1, ok, perr = 1'h0, urun = 1'h0;
  logic [7:0] busIn, busOut, hostBus, cmdData, wrData, rdData = 8'h00;
  logic [8:0] q;
  logic [7:0] wq[$];
  logic [1:0] devAddr = 2'h0;
  logic       busOe, busOddParityBitIn, busOddParityBitOut, busOddParityBitOe, hostBusOe;
  logic       hostPar, linkActiveFromHost, cmdStrobe, hostReset, hostDataStrobe, ackOut;
  logic       ackOe, availOut, availOe, driveAttention, driveAttentionOe, turnOut, turnOe;
  logic       cmdValid, wrValid, rdReady, parityErr, underrun, linkActive, selected;
  logic       parityEnable = 1'h0, selectHit = 1'h0, selectMiss = 1'h0, mechReady = 1'h1;
  logic       readMode = 1'h0, searchActive = 1'h0, streamActive = 1'h0, exceptionIn = 1'h0;
  logic       attnClear = 1'h0, cmdReady = 1'h0, wrReady = 1'h0, rdValid = 1'h0;
  int         failures = 0, checkCount = 0, cyc = 0;

  always #12.5 clk = ~clk;
  // Released lines read as logic zero
  assign busIn = busOe ? busOut : hostBusOe ? hostBus : 8'h00;
  assign busOddParityBitIn = busOddParityBitOe ? busOddParityBitOut : hostBusOe & hostPar;

  tdp_drive_port tdp_drive_port_i (.*);
  tdp_host_model tdp_host_model_i (.*);

  // Log tape-side octets and parity flags; cut a hang short
  always @(posedge clk) begin
    if (wrValid === 1'h1 && wrReady) wq.push_back(wrData);
    if (parityErr === 1'h1) perr = 1'h1;
    if (underrun === 1'h1) urun = 1'h1;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      test_done();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task feed(input logic [7:0] d);
    int n;
    rdData = d;
    rdValid = 1'h1;
    n = 0;
    while (rdReady !== 1'h1 && n < 20) begin
      tick(1);
      n++;
    end
    tick(1);
    rdValid = 1'h0;
  endtask

  task t_reset();
    devAddr = 2'h1;
    tdp_host_model_i.pulseReset();
    tick(5);
    chk({selected, availOe, ackOe}, 3'h0);
    devAddr = 2'h0;
    tdp_host_model_i.pulseReset();
    tick(5);
    // Home drive owns the bus with attention up, so available stays low
    chk({selected, driveAttention, driveAttentionOe, ackOut, availOut, availOe, linkActive},
        7'h73);
  endtask

  task t_cmd();
    tdp_host_model_i.xfer(1'h1, 1'h1, 9'h0A5, 20, q, ok);
    chk({ok, cmdValid, cmdData}, 10'h3A5);
    cmdReady = 1'h1;
    tick(1);
    cmdReady = 1'h0;
    attnClear = 1'h1;
    mechReady = 1'h0;
    tick(1);
    attnClear = 1'h0;
    tdp_host_model_i.xfer(1'h1, 1'h1, 9'h03C, 12, q, ok);
    chk({ok, cmdValid}, 2'h0);
    tick(3);
    exceptionIn = 1'h1;
    tick(1);
    exceptionIn = 1'h0;
    tick(1);
    chk(driveAttention, 1'h1);
    tdp_host_model_i.xfer(1'h1, 1'h1, 9'h0C3, 20, q, ok);
    chk({ok, cmdValid, cmdData}, 10'h3C3);
    cmdReady = 1'h1;
    mechReady = 1'h1;
    selectMiss = 1'h1;
    tick(1);
    {cmdReady, selectMiss} = 2'h0;
    tick(2);
    chk(selected, 1'h0);
    selectHit = 1'h1;
    tick(1);
    selectHit = 1'h0;
    tick(2);
    chk(selected, 1'h1);
  endtask

  // Two-entry buffer fills, third octet waits until the tape side drains
  task t_write();
    parityEnable = 1'h1;
    tdp_host_model_i.xfer(1'h0, 1'h1, {~^8'h01, 8'h01}, 20, q, ok);
    tdp_host_model_i.xfer(1'h0, 1'h1, {~^8'h80, 8'h80}, 20, q, ok);
    fork
      tdp_host_model_i.xfer(1'h0, 1'h1, {~^8'h5A, 8'h5A}, 60, q, ok);
      begin
        tick(12);
        chk(ackOut, 1'h0);
        wrReady = 1'h1;
      end
    join
    tick(2);
    chk({ok, perr, wq[0], wq[1], wq[2]}, 26'h201805A);
    tdp_host_model_i.xfer(1'h0, 1'h1, 9'h011, 20, q, ok);
    tick(1);
    chk(perr, 1'h1);
    parityEnable = 1'h0;
    perr = 1'h0;
    tdp_host_model_i.xfer(1'h0, 1'h1, 9'h011, 20, q, ok);
    tick(1);
    chk(perr, 1'h0);
  endtask

  task t_read();
    parityEnable = 1'h1;
    readMode = 1'h1;
    tick(4);
    chk({turnOut, turnOe}, 2'h3);
    feed(8'h80);
    feed(8'h01);
    // Tape offers a third octet into a full buffer while streaming
    streamActive = 1'h1;
    rdData = 8'h33;
    rdValid = 1'h1;
    tick(2);
    rdValid = 1'h0;
    chk(urun, 1'h1);
    tdp_host_model_i.xfer(1'h0, 1'h0, 9'h000, 20, q, ok);
    chk({ok, q}, {1'h1, ~^8'h80, 8'h80});
    tdp_host_model_i.xfer(1'h0, 1'h0, 9'h000, 20, q, ok);
    chk({ok, q}, {1'h1, ~^8'h01, 8'h01});
    tdp_host_model_i.xfer(1'h0, 1'h0, 9'h000, 12, q, ok);
    chk(ok, 1'h0);
    streamActive = 1'h0;
  endtask

  // Octets met while searching never reach the host
  task t_search();
    searchActive = 1'h1;
    rdData = 8'h77;
    rdValid = 1'h1;
    tick(1);
    chk(rdReady, 1'h1);
    tick(2);
    rdValid = 1'h0;
    tdp_host_model_i.xfer(1'h0, 1'h0, 9'h000, 12, q, ok);
    chk(ok, 1'h0);
    searchActive = 1'h0;
  endtask

  task test_done();
    if (failures == 0 && checkCount > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Reset for three cycles, then the scenarios in turn
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk) reset = 1'h0;
    tick(2);
    t_reset();
    t_cmd();
    t_write();
    t_read();
    t_search();
    test_done();
  end
endmodule // tdp_drive_port_tb

/* tdp_host_model.sv */
`timescale 1ns/10ps

// Host controller: one strobe at a time, held until acknowledged or until lim cycles pass
module tdp_host_model (
  input  wire        clk,                // Clock
  input  wire        ackOut,             // Drive ack
  input  wire  [7:0] busIn,              // Resolved data
  input  wire        busOddParityBitIn,  // Resolved parity
  output logic [7:0] hostBus,            // Data driven
  output logic       hostBusOe,          // Data enable
  output logic       hostPar,            // Parity driven
  output logic       cmdStrobe,          // Command strobe
  output logic       hostDataStrobe,     // Data strobe
  output logic       hostReset,          // Bus reset
  output logic       linkActiveFromHost  // Link active
);
  // Idle lines; link held active all run
  initial begin
    {hostBus, hostBusOe, hostPar, cmdStrobe, hostDataStrobe, hostReset} = 13'h0;
    linkActiveFromHost = 1'h1;
  end

  // Long enough to cross the drive's synchroniser
  task pulseReset();
    @(negedge clk) hostReset = 1'h1;
    repeat (4) @(negedge clk);
    hostReset = 1'h0;
  endtask

  // Refused strobes are dropped after lim cycles so the run cannot hang
  task xfer(input logic cmd, input logic wr, input logic [8:0] d, input int lim,
            output logic [8:0] q, output logic ok);
    int n;
    @(negedge clk);
    {hostPar, hostBus} = d;
    hostBusOe = wr;
    if (cmd) cmdStrobe = 1'h1;
    else hostDataStrobe = 1'h1;
    n = 0;
    while (ackOut !== 1'h1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    ok = (ackOut === 1'h1);
    q = {busOddParityBitIn, busIn};
    {cmdStrobe, hostDataStrobe, hostBusOe} = 3'h0;
    {hostPar, hostBus} = ~d; // Stale value never passes for fresh data
    n = 0;
    while (ackOut === 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
  endtask
endmodule // tdp_host_model

/* tdp_pair_buf.v */
`timescale 1ns/10ps
`include "tdp_consts.vh"

// Two-entry buffer with valid/ready on both sides; flush empties it
module tdp_pair_buf #(
  parameter WIDTH = `TDP_OCTET_W
) (
  input  wire             clk,      // System clock
  input  wire             reset,    // Async reset, active high
  input  wire             flush,    // Synchronous empty
  input  wire             inValid,  // Source offers a word
  output wire             inReady,  // Room for a word
  input  wire [WIDTH-1:0] inData,   // Word from source
  output wire             outValid, // Word available
  input  wire             outReady, // Sink takes the word
  output wire [WIDTH-1:0] outData   // Oldest word
);

  reg [WIDTH-1:0]          head_ff;
  reg [WIDTH-1:0]          tail_ff;
  reg [`TDP_BUF_CNT_W-1:0] count_ff;
  wire                     push;
  wire                     pop;

  assign inReady  = (count_ff != `TDP_BUF_DEPTH);
  assign outValid = (count_ff != {`TDP_BUF_CNT_W{1'b0}});
  assign outData  = head_ff;
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Head is the oldest word; tail only used when both entries hold data
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      head_ff  <= {WIDTH{1'b0}};
      tail_ff  <= {WIDTH{1'b0}};
      count_ff <= {`TDP_BUF_CNT_W{1'b0}};
    end else if (flush) begin
      count_ff <= {`TDP_BUF_CNT_W{1'b0}};
    end else begin
      case ({push, pop})
        2'b10: begin
          if (count_ff == {`TDP_BUF_CNT_W{1'b0}}) begin
            head_ff <= inData;
          end else begin
            tail_ff <= inData;
          end
          count_ff <= count_ff + 2'h1;
        end
        2'b01: begin
          head_ff  <= tail_ff;
          count_ff <= count_ff - 2'h1;
        end
        2'b11: begin
          // With one word held the new word becomes the head directly
          if (count_ff == 2'h1) begin
            head_ff <= inData;
          end else begin
            head_ff <= tail_ff;
            tail_ff <= inData;
          end
        end
        default: begin
          head_ff <= head_ff;
        end
      endcase
    end
  end

endmodule // tdp_pair_buf
